//--- core/alo_core.sv
// accumulator, file index and carry for the accumulator load group
// assumes memory data for the current data pointer arrives in the same
// cycle as the instruction; other instructions own the carry writes
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// RULE_01 - first wake control load copies into accumulator
// RULE_02 - opcode 1001011010 loads second wake control
// RULE_03 - display control load copies into accumulator
// RULE_04 - 101100jjjj loads accumulator from memory at pointer
// RULE_05 - same instruction xors index register with immediate
module alo_core #(
  parameter logic [9:0] OP_WAKE1 = alo_pkg::ALO_OP_WAKE1_DEF,
  parameter logic [9:0] OP_DISP  = alo_pkg::ALO_OP_DISP_DEF
) (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                reset,
  // instruction
  input  wire logic                instr_valid,
  input  wire logic [9:0]          instr_word,
  // sources
  input  wire logic [3:0]          wake_ctrl_reg_first,
  input  wire logic [3:0]          wake_ctrl_reg_second,
  input  wire logic [3:0]          display_ctrl_reg_first,
  input  wire logic [3:0]          ram_rdata,
  // carry written by the rest of the core
  input  wire logic                carry_we,
  input  wire logic                carry_d,
  // state
  output logic [3:0]               acc_q,
  output logic [3:0]               index_q,
  output logic                     carry_flag_q,
  output logic                     skip_q,
  output var alo_pkg::alo_sel_t    read_sel_q
);

  alo_pkg::alo_sel_t sel;
  logic [3:0]        imm;
  logic [3:0]        acc_d;
  logic [3:0]        index_d;

  alo_decode #(
    .OP_WAKE1 (OP_WAKE1),
    .OP_DISP  (OP_DISP)
  ) u_decode (
    .valid (instr_valid),
    .word  (instr_word),
    .sel   (sel),
    .imm   (imm)
  );

  always_comb begin
    acc_d = acc_q;
    if (sel.wake1) begin
      acc_d = wake_ctrl_reg_first;                  // see RULE_01
    end else if (sel.wake2) begin
      acc_d = wake_ctrl_reg_second;                 // see RULE_02
    end else if (sel.disp) begin
      acc_d = display_ctrl_reg_first;               // see RULE_03
    end else if (sel.ram) begin
      acc_d = ram_rdata;                            // see RULE_04
    end
  end

  // memory address uses the old index, so the xor lands afterwards
  always_comb begin
    index_d = index_q;
    if (sel.ram) begin
      index_d = index_q ^ imm;                      // see RULE_05
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      acc_q <= alo_pkg::ALO_ACC_RST;
    end else begin
      acc_q <= acc_d;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      index_q <= alo_pkg::ALO_INDEX_RST;
    end else begin
      index_q <= index_d;
    end
  end

  // these loads never touch carry; only the rest of the core does
  always_ff @(posedge clock) begin
    if (reset) begin
      carry_flag_q <= alo_pkg::ALO_CARRY_RST;
    end else if (carry_we && !(sel.wake1 || sel.wake2 || sel.disp ||
                               sel.ram)) begin
      carry_flag_q <= carry_d;
    end
  end

  // no load in this group ever requests a skip
  always_ff @(posedge clock) begin
    if (reset) begin
      skip_q <= 1'b0;
    end else begin
      skip_q <= 1'b0;
    end
  end

  // one-cycle echo of what was read, for read side effects downstream
  always_ff @(posedge clock) begin
    if (reset) begin
      read_sel_q <= alo_pkg::ALO_SEL_NONE;
    end else begin
      read_sel_q <= sel;
    end
  end

  // assertions
  wake_first_load_a: assert property ( // see RULE_01
    @(posedge clock) disable iff (reset)
    instr_valid && instr_word == OP_WAKE1
    |=> acc_q == $past(wake_ctrl_reg_first))
    else $error("wake first load wrong");

  wake_first_sel_a: assert property ( // see RULE_01
    @(posedge clock) disable iff (reset)
    instr_valid && instr_word == OP_WAKE1
    |=> read_sel_q.wake1)
    else $error("wake first read select missing");

  wake_second_load_a: assert property ( // see RULE_02
    @(posedge clock) disable iff (reset)
    instr_valid && instr_word == 10'h25A
    |=> acc_q == $past(wake_ctrl_reg_second) && read_sel_q.wake2)
    else $error("wake second load wrong");

  wake_second_keep_a: assert property ( // see RULE_02
    @(posedge clock) disable iff (reset)
    instr_valid && instr_word == 10'h25A
    |=> $stable(carry_flag_q) && !skip_q)
    else $error("wake second load disturbed carry or skip");

  display_load_a: assert property ( // see RULE_03
    @(posedge clock) disable iff (reset)
    instr_valid && instr_word == OP_DISP
    |=> acc_q == $past(display_ctrl_reg_first))
    else $error("display load wrong");

  display_keep_a: assert property ( // see RULE_03
    @(posedge clock) disable iff (reset)
    instr_valid && instr_word == OP_DISP
    |=> read_sel_q.disp && $stable(carry_flag_q) && !skip_q)
    else $error("display load select, carry or skip wrong");

  ram_load_carry_a: assert property ( // see RULE_04
    @(posedge clock) disable iff (reset)
    instr_valid && instr_word[9:4] == 6'h2C
    |=> acc_q == $past(ram_rdata) && $stable(carry_flag_q) && !skip_q)
    else $error("memory load wrong");

  ram_sel_pulse_a: assert property ( // see RULE_04
    @(posedge clock) disable iff (reset)
    instr_valid && instr_word[9:4] == 6'h2C
    |=> read_sel_q.ram)
    else $error("memory read select missing");

  // an idle cycle loads nothing and reports no read
  idle_acc_hold_a: assert property ( // see RULE_04
    @(posedge clock) disable iff (reset)
    !instr_valid
    |=> $stable(acc_q) && read_sel_q == alo_pkg::ALO_SEL_NONE)
    else $error("idle cycle changed accumulator");

  unknown_word_hold_a: assert property ( // see RULE_04
    @(posedge clock) disable iff (reset)
    instr_valid && instr_word[9:6] == 4'h0 && instr_word != OP_WAKE1
    && instr_word != OP_DISP |=> $stable(acc_q) && $stable(index_q))
    else $error("unknown word changed state");

  index_xor_a: assert property ( // see RULE_05
    @(posedge clock) disable iff (reset)
    instr_valid && instr_word[9:4] == 6'h2C
    |=> index_q == ($past(index_q) ^ $past(instr_word[3:0])))
    else $error("index xor wrong");

  // other loads and invalid words must leave the index alone
  index_hold_a: assert property ( // see RULE_05
    @(posedge clock) disable iff (reset)
    !(instr_valid && instr_word[9:4] == 6'h2C)
    |=> $stable(index_q))
    else $error("index changed without memory load");

  load_no_skip_a: assert property ( // see RULE_01
    @(posedge clock) disable iff (reset)
    (sel.wake1 || sel.wake2 || sel.disp)
    |=> !skip_q && $stable(carry_flag_q))
    else $error("register load disturbed carry or skip");

  // carry writes from the rest of the core still land when idle
  carry_pass_a: assert property ( // see RULE_04
    @(posedge clock) disable iff (reset)
    carry_we && !instr_valid
    |=> carry_flag_q == $past(carry_d))
    else $error("carry write lost");

  reset_clear_a: assert property (@(posedge clock)
    reset |=> acc_q == alo_pkg::ALO_ACC_RST
    && index_q == alo_pkg::ALO_INDEX_RST && !skip_q
    && carry_flag_q == alo_pkg::ALO_CARRY_RST)
    else $error("reset left state behind");

  // main scenarios the bench must reach
  wake1_cov: cover property (@(posedge clock) disable iff (reset)
    sel.wake1);
  wake2_cov: cover property (@(posedge clock) disable iff (reset)
    sel.wake2 ##1 sel.wake2);
  disp_cov: cover property (@(posedge clock) disable iff (reset)
    sel.disp ##1 sel.wake2);
  ram_back_cov: cover property (@(posedge clock) disable iff (reset)
    sel.ram ##1 sel.ram);
  ram_xor_cov: cover property (@(posedge clock) disable iff (reset)
    sel.ram && imm == 4'hF);

endmodule : alo_core
`default_nettype wire

//--- core/alo_decode.sv
// opcode decoder for the accumulator load instruction group
// assumes the word is presented with a valid strobe in its execute cycle
`timescale 1ns/1ns
`default_nettype none
module alo_decode #(
  parameter logic [9:0] OP_WAKE1 = alo_pkg::ALO_OP_WAKE1_DEF,
  parameter logic [9:0] OP_DISP  = alo_pkg::ALO_OP_DISP_DEF
) (
  // instruction
  input  wire logic                  valid,
  input  wire logic [9:0]            word,
  // decoded
  output var  alo_pkg::alo_sel_t     sel,
  output var  logic [3:0]            imm
);

  always_comb begin
    sel       = alo_pkg::ALO_SEL_NONE;
    imm       = word[alo_pkg::ALO_IMM_LSB +: alo_pkg::ALO_NIB_W];
    if (valid) begin
      sel.wake1 = (word == OP_WAKE1);
      sel.wake2 = (word == alo_pkg::ALO_OP_WAKE2);
      sel.disp  = (word == OP_DISP);
      sel.ram   = (word[alo_pkg::ALO_PREFIX_LSB +: alo_pkg::ALO_PREFIX_W]
                   == alo_pkg::ALO_OP_RAM_PFX);
    end
  end

endmodule : alo_decode
`default_nettype wire

//--- core/alo_pkg.sv
// constants and carriers for the accumulator load instruction group
// assumes a 10-bit instruction word and 4-bit datapath
package alo_pkg;

  localparam int          ALO_WORD_W      = 10;
  localparam int          ALO_NIB_W       = 4;
  localparam int          ALO_PREFIX_W    = 6;
  localparam int          ALO_IMM_LSB     = 0;
  localparam int          ALO_PREFIX_LSB  = 4;
  localparam int          ALO_WORDS       = 1;
  localparam int          ALO_CYCLES      = 1;
  localparam logic [9:0]  ALO_OP_WAKE2    = 10'h25A;
  localparam logic [5:0]  ALO_OP_RAM_PFX  = 6'h2C;
  // opcodes for the first wake and display loads are not known here
  localparam logic [9:0]  ALO_OP_WAKE1_DEF = 10'h259;
  localparam logic [9:0]  ALO_OP_DISP_DEF  = 10'h24B;
  localparam logic [3:0]  ALO_ACC_RST     = 4'h0;
  localparam logic [3:0]  ALO_INDEX_RST   = 4'h0;
  localparam logic        ALO_CARRY_RST   = 1'b0;

  // one-hot read select toward the peripheral registers and memory
  typedef struct packed {
    logic ram;
    logic disp;
    logic wake2;
    logic wake1;
  } alo_sel_t;

  localparam alo_sel_t ALO_SEL_NONE = '{ram: 1'b0, disp: 1'b0,
                                        wake2: 1'b0, wake1: 1'b0};

endpackage : alo_pkg

//--- tb/alo_core_test.sv
// random and corner bench for the accumulator load core
// assumes alo_pkg and alo_core are compiled first
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
  err_total++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module alo_core_test;
  logic              clock = 1'b0;
  logic              reset = 1'b1;
  logic              instr_valid = 1'b0;
  logic [9:0]        instr_word = 10'h000;
  logic [3:0]        wake_ctrl_reg_first = 4'h0;
  logic [3:0]        wake_ctrl_reg_second = 4'h0;
  logic [3:0]        display_ctrl_reg_first = 4'h0;
  logic [3:0]        ram_rdata = 4'h0;
  logic              carry_we = 1'b0;
  logic              carry_d = 1'b0;
  logic [3:0]        acc_q;
  logic [3:0]        index_q;
  logic              carry_flag_q;
  logic              skip_q;
  alo_pkg::alo_sel_t read_sel_q;
  alo_pkg::alo_sel_t s;
  logic [3:0]        e_acc = 4'h0;
  logic [3:0]        e_idx = 4'h0;
  logic              e_cy = 1'b0;
  logic [9:0]        w;
  int                err_total = 0;
  int                compares = 0;
  logic [9:0]        corner [7] = '{alo_pkg::ALO_OP_WAKE1_DEF,
    alo_pkg::ALO_OP_WAKE2, alo_pkg::ALO_OP_DISP_DEF, 10'h2C0, 10'h2CF,
    10'h2CF, 10'h000};

  always #10 clock = ~clock;

  alo_core u_alo_core (.clock, .reset, .instr_valid, .instr_word,
    .wake_ctrl_reg_first, .wake_ctrl_reg_second, .display_ctrl_reg_first,
    .ram_rdata, .carry_we, .carry_d, .acc_q, .index_q, .carry_flag_q,
    .skip_q, .read_sel_q);

  function automatic alo_pkg::alo_sel_t exp_sel(input logic v,
                                                input logic [9:0] x);
    alo_pkg::alo_sel_t r;
    r = alo_pkg::ALO_SEL_NONE;
    if (v) begin
      r.wake1 = (x == alo_pkg::ALO_OP_WAKE1_DEF);
      r.wake2 = (x == alo_pkg::ALO_OP_WAKE2);
      r.disp  = (x == alo_pkg::ALO_OP_DISP_DEF);
      r.ram   = (x[9:4] == alo_pkg::ALO_OP_RAM_PFX);
    end
    return r;
  endfunction : exp_sel

  task automatic close_out;
    if (err_total == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  // entered just after an edge; every call is one back-to-back cycle
  task automatic step(input logic [9:0] x, input logic v, input logic r);
    reset = r;
    instr_valid = v;
    instr_word = x;
    wake_ctrl_reg_first = 4'($urandom);
    wake_ctrl_reg_second = 4'($urandom);
    display_ctrl_reg_first = 4'($urandom);
    ram_rdata = 4'($urandom);
    carry_we = 1'($urandom);
    carry_d = 1'($urandom);
    s = exp_sel(v & ~r, x);
    if (s.wake1) e_acc = wake_ctrl_reg_first;
    else if (s.wake2) e_acc = wake_ctrl_reg_second;
    else if (s.disp) e_acc = display_ctrl_reg_first;
    else if (s.ram) e_acc = ram_rdata;
    if (s.ram) e_idx = e_idx ^ x[3:0];
    // loads leave carry alone, so a concurrent write is dropped
    if (s == alo_pkg::ALO_SEL_NONE && carry_we) e_cy = carry_d;
    if (r) begin
      e_acc = alo_pkg::ALO_ACC_RST;
      e_idx = alo_pkg::ALO_INDEX_RST;
      e_cy = alo_pkg::ALO_CARRY_RST;
    end
    @(posedge clock);
    #1;
    `CHK("acc", e_acc, acc_q)
    `CHK("index", e_idx, index_q)
    `CHK("carry", e_cy, carry_flag_q)
    `CHK("skip", 1'b0, skip_q)
    `CHK("read_sel", s, read_sel_q)
  endtask : step

  initial begin
    void'($urandom(82181));
    repeat (20) @(posedge clock);
    #1;
    foreach (corner[i]) step(corner[i], 1'b1, 1'b0);
    for (int n = 0; n < 800; n++) begin
      w = corner[$urandom_range(6)];
      if (w[9:4] == alo_pkg::ALO_OP_RAM_PFX) w[3:0] = 4'($urandom);
      // low words never hit one of the four load opcodes
      if (w == 10'h000) w[5:0] = 6'($urandom);
      step(w, $urandom_range(7) != 0, n == 400);
    end
    close_out();
  end
endmodule : alo_core_test
`undef CHK
`default_nettype wire
